// file: design/afs_ctrl.sv
// Function
// - Three-bit cutoff code sets second low-pass or high-pass bandwidth.
// - Low-pass path: ODR/2 when off, else codes give ODR/4 to ODR/800.
// - High-pass path selected: code 000 slope at ODR/4, others high-pass.
// - Reference mode acts only with high-pass path; resets to 0.
// - Quick settle acts only when leaving power-down; resets to 0.
// - Orientation source: 0 ODR/2 data, 1 second low-pass output.
// - First low-pass: ODR/2 high-performance, 780 Hz fixed otherwise.
// - Per-axis stamp bits, reset 1, replace axis LSB with pin active state.
// - Sensor select: 0 stamps gyroscope axes, 1 accelerometer axes.
// - Accelerometer extension enables stamping on accelerometer too.
// - Polarity bit: 0 pin active low, 1 active high.
// - Protocol-disable bit turns off only I3C when set; default 0.
// - Timestamp enable starts counter, read as bytes 40h to 43h.
`timescale 1ns/1ps
`default_nettype none

module afs_ctrl (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wr_data,
	output logic      [7:0]  rd_data,
	input  wire logic        sample_tick,
	input  wire logic        high_perf_mode,
	input  wire logic        leaving_power_down,
	input  wire logic        data_enable_pin,
	input  wire logic [15:0] gyro_x,
	input  wire logic [15:0] gyro_y,
	input  wire logic [15:0] gyro_z,
	input  wire logic [15:0] accel_x,
	input  wire logic [15:0] accel_y,
	input  wire logic [15:0] accel_z,
	output logic      [15:0] gyro_x_out,
	output logic      [15:0] gyro_y_out,
	output logic      [15:0] gyro_z_out,
	output logic      [15:0] accel_x_out,
	output logic      [15:0] accel_y_out,
	output logic      [15:0] accel_z_out,
	output logic      [1:0]  filter_path,
	output logic      [9:0]  bandwidth_divisor,
	output logic             first_lowpass_fixed,
	output logic             highpass_reference_on,
	output logic             quick_settle_on,
	output logic             orientation_source_select,
	output logic             i3c_off,
	output logic             time_count_on,
	output logic      [31:0] time_count
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [9:0] cutoff_div(input logic [2:0] code);
		case (code)
			3'h0:    cutoff_div = 10'h004;
			3'h1:    cutoff_div = 10'h00A;
			3'h2:    cutoff_div = 10'h014;
			3'h3:    cutoff_div = 10'h02D;
			3'h4:    cutoff_div = 10'h064;
			3'h5:    cutoff_div = 10'h0C8;
			3'h6:    cutoff_div = 10'h190;
			default: cutoff_div = 10'h320;
		endcase
	endfunction : cutoff_div

	function automatic logic [15:0] stamp(input logic [15:0] w,
		input logic on, input logic lvl);
		stamp = on ? {w[15:1], lvl} : w;
	endfunction : stamp

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] filter_reg;
	logic [7:0] stamp_reg;
	logic [7:0] timer_reg;
	logic [2:0] cutoff;
	logic       second_lowpass_on;
	logic       hp_sel;
	logic       pin_active;
	logic       gyro_stamp;
	logic       accel_stamp;
	afs_pkg::afs_path_t path;

	// Reserved bits are masked on write so stray host writes are harmless
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			filter_reg <= afs_pkg::RST_FILTER;
		end else if (wr_en && addr == afs_pkg::ADDR_FILTER) begin
			filter_reg <= wr_data & afs_pkg::MASK_FILTER;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stamp_reg <= afs_pkg::RST_STAMP;
		end else if (wr_en && addr == afs_pkg::ADDR_STAMP) begin
			stamp_reg <= wr_data & afs_pkg::MASK_STAMP;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timer_reg <= afs_pkg::RST_TIMER;
		end else if (wr_en && addr == afs_pkg::ADDR_TIMER) begin
			timer_reg <= wr_data & afs_pkg::MASK_TIMER;
		end
	end

	// ----------------------------------------------------------------
	// Timestamp counter
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			time_count <= 32'h0000_0000;
		end else if (timer_reg[afs_pkg::TS_EN_BIT]) begin
			time_count <= time_count + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				afs_pkg::ADDR_FILTER: rd_data <= filter_reg;
				afs_pkg::ADDR_STAMP:  rd_data <= stamp_reg;
				afs_pkg::ADDR_TIMER:  rd_data <= timer_reg;
				afs_pkg::ADDR_TS0:    rd_data <= time_count[7:0];
				afs_pkg::ADDR_TS0 + 8'h01: rd_data <= time_count[15:8];
				afs_pkg::ADDR_TS0 + 8'h02: rd_data <= time_count[23:16];
				afs_pkg::ADDR_TS3:    rd_data <= time_count[31:24];
				default:              rd_data <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Filter selection
	// ----------------------------------------------------------------
	// Second low-pass enable lives in another register; held on here
	// so the cutoff code always steers the low-pass path.
	assign second_lowpass_on = 1'b1;
	assign cutoff = filter_reg[afs_pkg::CUTOFF_LSB +: 3];
	assign hp_sel = filter_reg[afs_pkg::HP_SEL_BIT];

	always_comb begin
		if (hp_sel)
			path = (cutoff == 3'h0) ? afs_pkg::AFS_PATH_SLOPE :
				afs_pkg::AFS_PATH_HP;
		else if (second_lowpass_on)
			path = afs_pkg::AFS_PATH_LP2;
		else
			path = afs_pkg::AFS_PATH_LP1;
	end

	// ----------------------------------------------------------------
	// Filter outputs
	// ----------------------------------------------------------------

	// Settings change only at sample boundaries to avoid mid-sample glitches
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			filter_path <= 2'(afs_pkg::AFS_PATH_LP1);
		end else if (sample_tick) begin
			filter_path <= 2'(path);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bandwidth_divisor <= afs_pkg::BW_DIV_HALF;
		end else if (sample_tick) begin
			bandwidth_divisor <= (path == afs_pkg::AFS_PATH_LP1) ?
				afs_pkg::BW_DIV_HALF : cutoff_div(cutoff);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			highpass_reference_on <= 1'b0;
		end else if (sample_tick) begin
			highpass_reference_on <=
				filter_reg[afs_pkg::HP_REF_BIT] & hp_sel;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			quick_settle_on <= 1'b0;
		end else if (sample_tick) begin
			quick_settle_on <=
				filter_reg[afs_pkg::QSETTLE_BIT] & leaving_power_down;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			orientation_source_select <= 1'b0;
		end else if (sample_tick) begin
			orientation_source_select <=
				filter_reg[afs_pkg::ORIENT_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			first_lowpass_fixed <= 1'b0;
		end else if (sample_tick) begin
			first_lowpass_fixed <= ~high_perf_mode;
		end
	end

	// ----------------------------------------------------------------
	// Data-enable stamping
	// ----------------------------------------------------------------
	assign pin_active = data_enable_pin ~^
		stamp_reg[afs_pkg::STAMP_POL_BIT];
	assign gyro_stamp = ~stamp_reg[afs_pkg::STAMP_SEL_BIT];
	assign accel_stamp = stamp_reg[afs_pkg::STAMP_SEL_BIT] |
		stamp_reg[afs_pkg::STAMP_EXT_BIT];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gyro_x_out <= 16'h0000;
		end else if (sample_tick) begin
			gyro_x_out <= stamp(gyro_x,
				gyro_stamp & stamp_reg[afs_pkg::STAMP_X_BIT], pin_active);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gyro_y_out <= 16'h0000;
		end else if (sample_tick) begin
			gyro_y_out <= stamp(gyro_y,
				gyro_stamp & stamp_reg[afs_pkg::STAMP_Y_BIT], pin_active);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gyro_z_out <= 16'h0000;
		end else if (sample_tick) begin
			gyro_z_out <= stamp(gyro_z,
				gyro_stamp & stamp_reg[afs_pkg::STAMP_Z_BIT], pin_active);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			accel_x_out <= 16'h0000;
		end else if (sample_tick) begin
			accel_x_out <= stamp(accel_x,
				accel_stamp & stamp_reg[afs_pkg::STAMP_X_BIT], pin_active);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			accel_y_out <= 16'h0000;
		end else if (sample_tick) begin
			accel_y_out <= stamp(accel_y,
				accel_stamp & stamp_reg[afs_pkg::STAMP_Y_BIT], pin_active);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			accel_z_out <= 16'h0000;
		end else if (sample_tick) begin
			accel_z_out <= stamp(accel_z,
				accel_stamp & stamp_reg[afs_pkg::STAMP_Z_BIT], pin_active);
		end
	end

	// ----------------------------------------------------------------
	// Protocol and timer status
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			i3c_off <= 1'b0;
		end else begin
			i3c_off <= stamp_reg[afs_pkg::PROT_OFF_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			time_count_on <= 1'b0;
		end else begin
			time_count_on <= timer_reg[afs_pkg::TS_EN_BIT];
		end
	end

endmodule : afs_ctrl
`default_nettype wire

// file: include/afs_pkg.sv
package afs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FILTER = 8'h17;
	localparam logic [7:0] ADDR_STAMP  = 8'h18;
	localparam logic [7:0] ADDR_TIMER  = 8'h19;
	localparam logic [7:0] ADDR_TS0    = 8'h40;
	localparam logic [7:0] ADDR_TS3    = 8'h43;

	// ----------------------------------------------------------------
	// Reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_FILTER  = 8'h00;
	localparam logic [7:0] RST_STAMP   = 8'hE0;
	localparam logic [7:0] RST_TIMER   = 8'h00;
	localparam logic [7:0] MASK_FILTER = 8'hFD;
	localparam logic [7:0] MASK_STAMP  = 8'hFE;
	localparam logic [7:0] MASK_TIMER  = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CUTOFF_LSB   = 5;
	localparam int HP_REF_BIT   = 4;
	localparam int QSETTLE_BIT  = 3;
	localparam int HP_SEL_BIT   = 2;
	localparam int ORIENT_BIT   = 0;
	localparam int STAMP_X_BIT  = 7;
	localparam int STAMP_Y_BIT  = 6;
	localparam int STAMP_Z_BIT  = 5;
	localparam int STAMP_SEL_BIT = 4;
	localparam int STAMP_EXT_BIT = 3;
	localparam int STAMP_POL_BIT = 2;
	localparam int PROT_OFF_BIT = 1;
	localparam int TS_EN_BIT    = 5;

	// ----------------------------------------------------------------
	// Bandwidth codes: divisor of the output data rate
	// ----------------------------------------------------------------
	localparam logic [9:0] BW_DIV_HALF = 10'h002;

	typedef enum logic [1:0] {
		AFS_PATH_LP1,
		AFS_PATH_LP2,
		AFS_PATH_SLOPE,
		AFS_PATH_HP
	} afs_path_t;

endpackage : afs_pkg

// file: dv/afs_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module afs_ctrl_chk (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        rd_en,
	input wire logic [7:0]  addr,
	input wire logic [7:0]  rd_data,
	input wire logic        sample_tick,
	input wire logic [15:0] gyro_x,
	input wire logic [15:0] gyro_x_out,
	input wire logic [1:0]  filter_path,
	input wire logic [9:0]  bandwidth_divisor,
	input wire logic        i3c_off,
	input wire logic        time_count_on,
	input wire logic [31:0] time_count
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	read_hold_a: assert property (!rd_en |=> $stable(rd_data))
		else $error("read data moved");
	timer_read_a: assert property (rd_en && addr == 8'h19 |=>
		rd_data == {2'h0, time_count_on, 5'h00}) else $error("timer");
	stamp_read_a: assert property (rd_en && addr == 8'h18 |=>
		rd_data[1:0] == {i3c_off, 1'h0}) else $error("stamp reg");
	unmapped_read_a: assert property (rd_en && addr == 8'h20 |=>
		rd_data == 8'h00) else $error("unmapped");
	count_step_a: assert property (time_count_on |->
		time_count == $past(time_count) + 32'h1) else $error("count");
	count_hold_a: assert property (!time_count_on |->
		$stable(time_count)) else $error("count held");
	path_hold_a: assert property (!sample_tick |=>
		$stable(filter_path) && $stable(bandwidth_divisor)) else $error("path");
	slope_div_a: assert property (filter_path == 2'h2 |->
		bandwidth_divisor == 10'h004) else $error("slope");
	half_div_a: assert property (filter_path == 2'h0 |->
		bandwidth_divisor == 10'h002) else $error("half");
	axis_upper_a: assert property (sample_tick |=>
		(gyro_x_out ^ $past(gyro_x)) <= 16'h0001) else $error("axis");
endmodule : afs_ctrl_chk
`default_nettype wire

// file: dv/afs_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Host side of the register port
// ----
module afs_host (
	input  wire logic       sys_clk,
	input  wire logic [7:0] rd_data,
	output logic            wr_en,
	output logic            rd_en,
	output logic      [7:0] addr,
	output logic      [7:0] wr_data
);
	initial begin
		wr_en = 1'h0;
		rd_en = 1'h0;
		addr = 8'h00;
		wr_data = 8'h00;
	end
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr_en <= 1'h1;
		addr <= a;
		wr_data <= d & ((a == 8'h17) ? 8'hFD : (a == 8'h18) ? 8'hFE : 8'h20);
		@(posedge sys_clk);
		wr_en <= 1'h0;
		wr_data <= ~d;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		rd_en <= 1'h1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'h0;
		#1 d = rd_data;
	endtask : read_reg
endmodule : afs_host
`default_nettype wire

// file: dv/test_afs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module test_afs_ctrl;
	logic sys_clk, rst, wr_en, rd_en, sample_tick, high_perf_mode;
	logic leaving_power_down, data_enable_pin, first_lowpass_fixed;
	logic highpass_reference_on, quick_settle_on, i3c_off, time_count_on;
	logic orientation_source_select;
	logic [7:0] addr, wr_data, rd_data, hi;
	logic [15:0] gyro_x_out, gyro_y_out, gyro_z_out;
	logic [15:0] accel_x_out, accel_y_out, accel_z_out;
	logic [1:0] filter_path;
	logic [9:0] bandwidth_divisor;
	logic [31:0] time_count;
	int n_errors = 0;
	int num_checks = 0;
	wire logic [15:0] gyro_x = {hi, 8'h10};
	wire logic [15:0] gyro_y = {hi, 8'h21};
	wire logic [15:0] gyro_z = {hi, 8'h30};
	wire logic [15:0] accel_x = {hi, 8'h41};
	wire logic [15:0] accel_y = {hi, 8'h50};
	wire logic [15:0] accel_z = {hi, 8'h61};
	afs_ctrl dut_u (.*);
	afs_host host_u (.*);
	always #2.5 sys_clk = ~sys_clk;
	task automatic check(input string s, input logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask : check
	function automatic logic [15:0] st(logic [15:0] r, logic on, logic act);
		return on ? {r[15:1], act} : r;
	endfunction : st
	task automatic tick;
		@(posedge sys_clk);
		sample_tick <= 1'h1;
		@(posedge sys_clk);
		sample_tick <= 1'h0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic reset_values;
		logic [7:0] d;
		for (int i = 0; i < 3; i++) begin
			host_u.read_reg(8'h17 + 8'(i), d);
			check("reset value", (i == 1) ? 8'hE0 : 8'h00, d);
		end
	endtask : reset_values
	task automatic filter_modes;
		logic [7:0] d;
		logic [7:0] v;
		logic [9:0] dv [8] = '{10'h004, 10'h00A, 10'h014, 10'h02D,
			10'h064, 10'h0C8, 10'h190, 10'h320};
		for (int i = 0; i < 16; i++) begin
			v = {i[2:0], 2'h3, i[3], 1'h0, i[3]};
			@(posedge sys_clk);
			leaving_power_down <= i[0];
			high_perf_mode <= i[1];
			host_u.write_reg(8'h17, v);
			tick;
			tick;
			host_u.read_reg(8'h17, d);
			check("filter reg", v, d);
			check("path", i[3] ? ((i[2:0] == 0) ? 2'h2 : 2'h3) : 2'h1, filter_path);
			check("divisor", dv[i[2:0]], bandwidth_divisor);
			check("reference", i[3], highpass_reference_on);
			check("settle", i[0], quick_settle_on);
			check("orientation", i[3], orientation_source_select);
			check("lp1 fixed", !i[1], first_lowpass_fixed);
		end
	endtask : filter_modes
	task automatic stamp_modes;
		logic g;
		logic a;
		logic t;
		for (int i = 0; i < 128; i++) begin
			@(posedge sys_clk);
			hi <= 8'(i);
			data_enable_pin <= i[0] ^ i[1];
			host_u.write_reg(8'h18, {i[6:2], i[1], i[0], 1'h0});
			tick;
			g = !i[3];
			a = i[3] | i[2];
			t = !i[0];
			check("gyro x", st({hi, 8'h10}, g & i[6], t), gyro_x_out);
			check("gyro y", st({hi, 8'h21}, g & i[5], t), gyro_y_out);
			check("gyro z", st({hi, 8'h30}, g & i[4], t), gyro_z_out);
			check("accel x", st({hi, 8'h41}, a & i[6], t), accel_x_out);
			check("accel y", st({hi, 8'h50}, a & i[5], t), accel_y_out);
			check("accel z", st({hi, 8'h61}, a & i[4], t), accel_z_out);
			check("i3c off", i[0], i3c_off);
		end
	endtask : stamp_modes
	task automatic timer_run;
		logic [7:0] d;
		logic [31:0] t;
		host_u.write_reg(8'h19, 8'h20);
		#1 t = time_count;
		repeat (10) @(posedge sys_clk);
		#1 check("count", t + 32'hA, time_count);
		check("timer on", 32'h1, time_count_on);
		host_u.read_reg(8'h43, d);
		check("count top", 8'h00, d);
		host_u.write_reg(8'h19, 8'h00);
		repeat (2) @(posedge sys_clk);
		host_u.read_reg(8'h40, d);
		check("count low", 8'(t + 32'hE), d);
		check("count held", t + 32'hE, time_count);
		check("timer off", 32'h0, time_count_on);
		host_u.read_reg(8'h20, d);
		check("unmapped", 8'h00, d);
	endtask : timer_run
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_errors++;
		finish_test;
	end
	initial begin
		{sys_clk, rst, sample_tick, high_perf_mode} = 4'h5;
		{leaving_power_down, data_enable_pin, hi} = 10'h000;
		repeat (20) @(posedge sys_clk);
		rst <= 1'h0;
		reset_values;
		filter_modes;
		stamp_modes;
		timer_run;
		finish_test;
	end
endmodule : test_afs_ctrl
bind afs_ctrl afs_ctrl_chk chk_u (.*);
`default_nettype wire
